// ==== tmr_map.vh ====
// register addresses, field positions, reset values and divider counts of the dual timer
`ifndef TMR_MAP_VH
`define TMR_MAP_VH
`define TMR_ADDR_CTRL 8'h88
`define TMR_ADDR_MODE 8'h89
`define TMR_ADDR_T0_LOW 8'h8A
`define TMR_ADDR_T1_LOW 8'h8B
`define TMR_ADDR_T0_HIGH 8'h8C
`define TMR_ADDR_T1_HIGH 8'h8D
`define TMR_ADDR_AUX_TWO 8'hA3
`define TMR_ADDR_AUX_THREE 8'hA4
`define TMR_ADDR_GATE_EXT 8'hA5
`define TMR_RESET_BYTE 8'h00
`define TMR_CTRL_TF1 7
`define TMR_CTRL_TR1 6
`define TMR_CTRL_TF0 5
`define TMR_CTRL_TR0 4
`define TMR_MODE_T1_GATE 7
`define TMR_MODE_T1_CT 6
`define TMR_MODE_T0_GATE 3
`define TMR_MODE_T0_CT 2
`define TMR_AUX2_T1_X12 3
`define TMR_AUX2_T0_X12 2
`define TMR_AUX2_T1_CKOE 1
`define TMR_AUX2_T0_CKOE 0
`define TMR_AUX3_T0_XL 0
`define TMR_GEXT_T1_G1 1
`define TMR_GEXT_T0_G1 0
`define TMR_DIV_BASE 4'd12
`define TMR_DIV_STEP 2'd3
`define TMR_OPM_PWM 2'b00
`define TMR_OPM_WIDE 2'b01
`define TMR_OPM_RELOAD 2'b10
`define TMR_OPM_SPLIT 2'b11
`endif

// ==== tmr_pin_edge.v ====
// two-stage synchroniser for a pin with a registered falling-edge detector
`timescale 1ns/1ps
module tmr_pin_edge (
  input wire core_clk_in,
  input wire rstn_in,
  input wire pin_in,
  output wire level_out,
  output reg fall_out
);
  reg meta_r; // first stage, read only by sync_r
  reg sync_r; // safe synchronised level
  reg prev_r; // level one clock earlier

  assign level_out = sync_r;

  // high sample followed by low sample gives one pulse
  always @(posedge core_clk_in) begin
    if (!rstn_in) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
      fall_out <= 1'b0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
      fall_out <= prev_r & ~sync_r;
    end
  end
endmodule // tmr_pin_edge

// ==== tmr_dual_top.v ====
// two classic timer/counters with pwm, auto-reload, split mode and clock output
`timescale 1ns/1ps
`include "tmr_map.vh"
module tmr_dual_top (
  input wire core_clk_in,
  input wire rstn_in,
  input wire [7:0] sfr_addr_in,
  input wire sfr_wr_in,
  input wire [7:0] sfr_wdata_in,
  input wire sfr_rd_in,
  output reg [7:0] sfr_rdata_out,
  input wire timer_zero_count_pin_in,
  input wire timer_one_count_pin_in,
  input wire ext_int0_pin_in,
  input wire ext_int1_pin_in,
  input wire timer_two_flag_in,
  input wire timer_three_flag_in,
  input wire keypad_event_in,
  input wire serial_tx_flag_in,
  input wire slow_osc_tick_in,
  input wire wdt_prescale_tick_in,
  output reg timer_zero_clkout_pin_out,
  output reg timer_one_clkout_pin_out,
  output reg timer_zero_irq_out,
  output reg timer_one_irq_out,
  output reg timer_one_overflow_pulse_out
);
  // software visible registers
  reg [7:0] ctrl_r; // run bits and overflow flags
  reg [7:0] mode_r; // gate, counter select and mode fields
  reg [7:0] tl0_r; // timer_zero_low_count
  reg [7:0] th0_r; // timer_zero_high_count
  reg [7:0] tl1_r; // timer_one_low_count
  reg [7:0] th1_r; // timer_one_high_count
  reg [3:0] aux2_r; // fast selects and clock output enables
  reg aux3_xl_r; // timer_zero_prescale_extend
  reg [1:0] gext_r; // high bits of the gate select fields
  // prescaler state
  reg [3:0] div12_cnt_r; // counts clocks within one machine cycle
  reg [1:0] div48_cnt_r; // counts machine cycles by four
  reg [1:0] div192_cnt_r; // counts quarter groups by four
  reg tick12_r; // one clock per twelve
  reg tick48_r; // one clock per forty-eight
  reg tick192_r; // one clock per hundred ninety-two
  // clock output toggles and pwm levels
  reg tog0_r;
  reg tog1_r;
  reg timer_one_overflow_pulse_r; // timer one overflow from last clock, feeds timer zero source
  wire t0_lvl_unused;
  wire t1_lvl_unused;
  wire t0_fall; // falling edge on timer zero count pin
  wire t1_fall; // falling edge on timer one count pin
  wire int0_lvl; // synchronised external interrupt levels
  wire int1_lvl;
  wire int0_fall_unused;
  wire int1_fall_unused;
  // decoded controls
  wire tr0 = ctrl_r[`TMR_CTRL_TR0];
  wire tr1 = ctrl_r[`TMR_CTRL_TR1];
  wire cko0 = aux2_r[`TMR_AUX2_T0_CKOE];
  wire cko1 = aux2_r[`TMR_AUX2_T1_CKOE];
  wire x12_0 = aux2_r[`TMR_AUX2_T0_X12];
  wire x12_1 = aux2_r[`TMR_AUX2_T1_X12];
  wire ct0 = mode_r[`TMR_MODE_T0_CT];
  wire ct1 = mode_r[`TMR_MODE_T1_CT];
  wire [1:0] gsel0 = {gext_r[`TMR_GEXT_T0_G1], mode_r[`TMR_MODE_T0_GATE]};
  wire [1:0] gsel1 = {gext_r[`TMR_GEXT_T1_G1], mode_r[`TMR_MODE_T1_GATE]};
  // clock output mode overrides the mode field with auto-reload
  wire [1:0] opm0 = cko0 ? `TMR_OPM_RELOAD : mode_r[1:0];
  wire [1:0] opm1 = cko1 ? `TMR_OPM_RELOAD : mode_r[5:4];
  wire split0 = (opm0 == `TMR_OPM_SPLIT);
  wire hold1 = (opm1 == `TMR_OPM_SPLIT);

  // gate pass: true when the chosen source lets counting proceed
  function gate_ok;
    input [1:0] sel;
    input int_lvl;
    input tf_other;
    input misc;
    begin
      case (sel)
        2'b00: gate_ok = 1'b1;
        2'b01: gate_ok = int_lvl;
        2'b10: gate_ok = tf_other;
        default: gate_ok = misc;
      endcase
    end
  endfunction

  // one step of an eight-bit auto-reload or pwm counter
  function [8:0] step8;
    input [7:0] cnt;
    input [7:0] reload;
    begin
      if (cnt == 8'hFF) begin
        step8 = {1'b1, reload};
      end else begin
        step8 = {1'b0, cnt + 8'h01};
      end
    end
  endfunction

  tmr_pin_edge u_t0_pin (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .pin_in(timer_zero_count_pin_in),
    .level_out(t0_lvl_unused),
    .fall_out(t0_fall)
  );
  tmr_pin_edge u_t1_pin (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .pin_in(timer_one_count_pin_in),
    .level_out(t1_lvl_unused),
    .fall_out(t1_fall)
  );
  tmr_pin_edge u_int0_pin (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .pin_in(ext_int0_pin_in),
    .level_out(int0_lvl),
    .fall_out(int0_fall_unused)
  );
  tmr_pin_edge u_int1_pin (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .pin_in(ext_int1_pin_in),
    .level_out(int1_lvl),
    .fall_out(int1_fall_unused)
  );

  // clock source selection for both timers
  reg src0;
  reg src1;
  always @* begin
    case ({aux3_xl_r, x12_0, ct0})
      3'b000: src0 = tick12_r;
      3'b001: src0 = t0_fall;
      3'b010: src0 = 1'b1;
      3'b011: src0 = slow_osc_tick_in;
      3'b100: src0 = tick48_r;
      3'b101: src0 = wdt_prescale_tick_in;
      3'b110: src0 = tick192_r;
      default: src0 = timer_one_overflow_pulse_r;
    endcase
    case ({x12_1, ct1})
      2'b00: src1 = tick12_r;
      2'b01: src1 = t1_fall;
      2'b10: src1 = 1'b1;
      default: src1 = tick48_r;
    endcase
  end

  // split high byte is locked to timer function, never the pin
  wire src0_high = x12_0 ? 1'b1 : tick12_r;
  wire g0 = gate_ok(gsel0, int0_lvl, timer_two_flag_in, keypad_event_in);
  wire g1 = gate_ok(gsel1, int1_lvl, timer_three_flag_in, serial_tx_flag_in);
  wire en0 = src0 & tr0 & g0;
  // while timer zero is split, timer one loses its run bit and counts whenever its gate passes and it is not held in split mode
  wire en1 = src1 & (split0 | tr1) & g1 & ~hold1;
  wire en0_high = src0_high & tr1 & split0;

  // next count values and overflow events
  reg [7:0] tl0_nxt;
  reg [7:0] th0_nxt;
  reg [7:0] tl1_nxt;
  reg [7:0] th1_nxt;
  reg ovf0;
  reg ovf1;
  reg ovf0_high;
  reg [8:0] s0;
  reg [8:0] s1;
  reg [8:0] sh;
  always @* begin
    s0 = 9'h000;
    s1 = 9'h000;
    sh = 9'h000;
    tl0_nxt = tl0_r;
    th0_nxt = th0_r;
    tl1_nxt = tl1_r;
    th1_nxt = th1_r;
    ovf0 = 1'b0;
    ovf1 = 1'b0;
    ovf0_high = 1'b0;
    if (en0) begin
      case (opm0)
        `TMR_OPM_PWM: begin
          s0 = step8(tl0_r, 8'h00);
          tl0_nxt = s0[7:0];
          ovf0 = s0[8];
        end
        `TMR_OPM_WIDE: begin
          {th0_nxt, tl0_nxt} = {th0_r, tl0_r} + 16'h0001;
          ovf0 = ({th0_r, tl0_r} == 16'hFFFF);
        end
        default: begin
          s0 = step8(tl0_r, split0 ? 8'h00 : th0_r);
          tl0_nxt = s0[7:0];
          ovf0 = s0[8];
        end
      endcase
    end
    if (en0_high) begin
      sh = step8(th0_r, 8'h00);
      th0_nxt = sh[7:0];
      ovf0_high = sh[8];
    end
    if (en1) begin
      case (opm1)
        `TMR_OPM_PWM: begin
          s1 = step8(tl1_r, 8'h00);
          tl1_nxt = s1[7:0];
          ovf1 = s1[8];
        end
        `TMR_OPM_WIDE: begin
          {th1_nxt, tl1_nxt} = {th1_r, tl1_r} + 16'h0001;
          ovf1 = ({th1_r, tl1_r} == 16'hFFFF);
        end
        default: begin
          s1 = step8(tl1_r, th1_r);
          tl1_nxt = s1[7:0];
          ovf1 = s1[8];
        end
      endcase
    end
  end

  // overflow flags: hardware set wins over a software clear in the same clock
  wire set_tf0 = ovf0;
  wire set_tf1 = split0 ? ovf0_high : ovf1;
  wire wr_ctrl = sfr_wr_in & (sfr_addr_in == `TMR_ADDR_CTRL);

  // prescaler: divide by twelve, then twice by four
  always @(posedge core_clk_in) begin
    if (!rstn_in) begin
      div12_cnt_r <= 4'h0;
      div48_cnt_r <= 2'h0;
      div192_cnt_r <= 2'h0;
      tick12_r <= 1'b0;
      tick48_r <= 1'b0;
      tick192_r <= 1'b0;
    end else begin
      tick12_r <= 1'b0;
      tick48_r <= 1'b0;
      tick192_r <= 1'b0;
      if (div12_cnt_r == (`TMR_DIV_BASE - 4'd1)) begin
        div12_cnt_r <= 4'h0;
        tick12_r <= 1'b1;
        div48_cnt_r <= div48_cnt_r + 2'h1;
        if (div48_cnt_r == `TMR_DIV_STEP) begin
          tick48_r <= 1'b1;
          div192_cnt_r <= div192_cnt_r + 2'h1;
          if (div192_cnt_r == `TMR_DIV_STEP) begin
            tick192_r <= 1'b1;
          end
        end
      end else begin
        div12_cnt_r <= div12_cnt_r + 4'h1;
      end
    end
  end

  // register file and counters; a software write to a count byte wins over counting
  always @(posedge core_clk_in) begin
    if (!rstn_in) begin
      ctrl_r <= `TMR_RESET_BYTE;
      mode_r <= `TMR_RESET_BYTE;
      tl0_r <= `TMR_RESET_BYTE;
      th0_r <= `TMR_RESET_BYTE;
      tl1_r <= `TMR_RESET_BYTE;
      th1_r <= `TMR_RESET_BYTE;
      aux2_r <= 4'h0;
      aux3_xl_r <= 1'b0;
      gext_r <= 2'b00;
    end else begin
      tl0_r <= tl0_nxt;
      th0_r <= th0_nxt;
      tl1_r <= tl1_nxt;
      th1_r <= th1_nxt;
      if (wr_ctrl) begin
        ctrl_r[`TMR_CTRL_TR1] <= sfr_wdata_in[`TMR_CTRL_TR1];
        ctrl_r[`TMR_CTRL_TR0] <= sfr_wdata_in[`TMR_CTRL_TR0];
      end
      if (set_tf0) begin
        ctrl_r[`TMR_CTRL_TF0] <= 1'b1;
      end else if (wr_ctrl) begin
        ctrl_r[`TMR_CTRL_TF0] <= sfr_wdata_in[`TMR_CTRL_TF0];
      end
      if (set_tf1) begin
        ctrl_r[`TMR_CTRL_TF1] <= 1'b1;
      end else if (wr_ctrl) begin
        ctrl_r[`TMR_CTRL_TF1] <= sfr_wdata_in[`TMR_CTRL_TF1];
      end
      if (sfr_wr_in) begin
        case (sfr_addr_in)
          `TMR_ADDR_MODE: mode_r <= sfr_wdata_in;
          `TMR_ADDR_T0_LOW: tl0_r <= sfr_wdata_in;
          `TMR_ADDR_T0_HIGH: th0_r <= sfr_wdata_in;
          `TMR_ADDR_T1_LOW: tl1_r <= sfr_wdata_in;
          `TMR_ADDR_T1_HIGH: th1_r <= sfr_wdata_in;
          `TMR_ADDR_AUX_TWO: aux2_r <= sfr_wdata_in[3:0];
          `TMR_ADDR_AUX_THREE: aux3_xl_r <= sfr_wdata_in[`TMR_AUX3_T0_XL];
          `TMR_ADDR_GATE_EXT: gext_r <= sfr_wdata_in[1:0];
          default: ;
        endcase
      end
    end
  end

  // registered read data; unknown addresses and unused bits read zero
  always @(posedge core_clk_in) begin
    if (!rstn_in) begin
      sfr_rdata_out <= 8'h00;
    end else if (sfr_rd_in) begin
      case (sfr_addr_in)
        `TMR_ADDR_CTRL: sfr_rdata_out <= {ctrl_r[7:4], 4'h0};
        `TMR_ADDR_MODE: sfr_rdata_out <= mode_r;
        `TMR_ADDR_T0_LOW: sfr_rdata_out <= tl0_r;
        `TMR_ADDR_T0_HIGH: sfr_rdata_out <= th0_r;
        `TMR_ADDR_T1_LOW: sfr_rdata_out <= tl1_r;
        `TMR_ADDR_T1_HIGH: sfr_rdata_out <= th1_r;
        `TMR_ADDR_AUX_TWO: sfr_rdata_out <= {4'h0, aux2_r};
        `TMR_ADDR_AUX_THREE: sfr_rdata_out <= {7'h00, aux3_xl_r};
        `TMR_ADDR_GATE_EXT: sfr_rdata_out <= {6'h00, gext_r};
        default: sfr_rdata_out <= 8'h00;
      endcase
    end
  end

  // clock output toggles once per overflow: period 2*(256-reload) input ticks
  always @(posedge core_clk_in) begin
    if (!rstn_in) begin
      tog0_r <= 1'b0;
      tog1_r <= 1'b0;
      timer_one_overflow_pulse_r <= 1'b0;
      timer_zero_clkout_pin_out <= 1'b0;
      timer_one_clkout_pin_out <= 1'b0;
      timer_zero_irq_out <= 1'b0;
      timer_one_irq_out <= 1'b0;
      timer_one_overflow_pulse_out <= 1'b0;
    end else begin
      if (!cko0) begin
        tog0_r <= 1'b0;
      end else if (ovf0) begin
        tog0_r <= ~tog0_r;
      end
      if (!cko1) begin
        tog1_r <= 1'b0;
      end else if (ovf1) begin
        tog1_r <= ~tog1_r;
      end
      // one overflow rate feeds baud logic and the clock pin alike
      timer_one_overflow_pulse_r <= ovf1;
      timer_one_overflow_pulse_out <= ovf1;
      // pin shows the square wave when enabled, else the pwm compare level
      timer_zero_clkout_pin_out <= cko0 ? tog0_r : (tl0_r >= th0_r);
      timer_one_clkout_pin_out <= cko1 ? tog1_r : (tl1_r >= th1_r);
      timer_zero_irq_out <= ctrl_r[`TMR_CTRL_TF0] & ~cko0;
      // split high byte owns timer one's interrupt even when timer one clocks out
      timer_one_irq_out <= ctrl_r[`TMR_CTRL_TF1] & (split0 | ~cko1);
    end
  end
endmodule // tmr_dual_top

// ==== tmr_dual_props.sv ====
// port assertions for the dual timer
`timescale 1ns/1ps
module tmr_dual_props (
  input wire core_clk_in,
  input wire rstn_in,
  input wire [7:0] sfr_addr_in,
  input wire sfr_wr_in,
  input wire [7:0] sfr_wdata_in,
  input wire sfr_rd_in,
  input wire [7:0] sfr_rdata_out,
  input wire timer_zero_irq_out,
  input wire timer_one_irq_out,
  input wire timer_one_overflow_pulse_out
);
  reg [7:0] ctl_r, mod_r, ax2_r; // shadows of written control bytes
  reg [3:0] gap_r; // clocks since last pulse, saturating
  reg wr_r; // a write since the last pulse spoils the gap
  wire ovf = timer_one_overflow_pulse_out;
  wire slow1 = ~mod_r[6] & ~ax2_r[3]; // timer one on sysclk/12
  wire hold1 = ~ax2_r[1] & mod_r[5:4] == 2'b11 & mod_r[1:0] != 2'b11;
  wire stop1 = ~ctl_r[6] & mod_r[1:0] != 2'b11; // split mode ignores run
  // split high byte owns timer one's interrupt, so the mask only holds outside split
  wire out1 = ax2_r[1] & mod_r[1:0] != 2'b11;
  // only run, mode and select bits are used, which hardware never alters
  always @(posedge core_clk_in) begin
    if (!rstn_in) begin
      ctl_r <= 8'h00;
      mod_r <= 8'h00;
      ax2_r <= 8'h00;
      gap_r <= 4'h0;
      wr_r <= 1'b0;
    end else begin
      if (sfr_wr_in && sfr_addr_in == 8'h88) ctl_r <= sfr_wdata_in;
      if (sfr_wr_in && sfr_addr_in == 8'h89) mod_r <= sfr_wdata_in;
      if (sfr_wr_in && sfr_addr_in == 8'hA3) ax2_r <= sfr_wdata_in;
      wr_r <= sfr_wr_in | (wr_r & ~ovf);
      gap_r <= ovf ? 4'h0 : (gap_r == 4'hF ? gap_r : gap_r + 4'h1);
    end
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  a_rd_hold: assert property (!$past(sfr_rd_in) |-> $stable(sfr_rdata_out))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (sfr_rd_in && sfr_addr_in == 8'h00 |=> sfr_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_aux_upper_zero: assert property (sfr_rd_in && sfr_addr_in == 8'hA3 |=> !sfr_rdata_out[7:4])
    else $error("aux upper bits not zero");
  a_irq_zero_mask: assert property (ax2_r[0] && $past(ax2_r[0]) |-> !timer_zero_irq_out)
    else $error("timer zero irq in clock out");
  a_irq_one_mask: assert property (out1 && $past(out1) |-> !timer_one_irq_out)
    else $error("timer one irq in clock out");
  a_slow_tick_gap: assert property (ovf && !wr_r && slow1 |-> gap_r >= 4'd11)
    else $error("slow timer ticks too fast");
  a_mode3_hold: assert property (hold1 [*3] |-> !ovf)
    else $error("timer one moved in mode 3");
  a_stop_quiet: assert property (stop1 && $past(stop1, 2) |-> !ovf)
    else $error("overflow while stopped");
  cover property (ovf && slow1);
  cover property (hold1 && sfr_rd_in);
  cover property (timer_one_irq_out);
  cover property (ax2_r[1] && ovf);
endmodule // tmr_dual_props

// ==== tmr_pin_model.sv ====
// count pin driver and clock output period monitor
`timescale 1ns/1ps
module tmr_pin_model (
  input wire core_clk_in,
  input wire clkout_in,
  output reg count_pin_out
);
  reg prev_r = 1'b0; // clock output level at the previous edge
  reg [7:0] run_r = 8'h00; // clocks since the last rising edge
  reg [7:0] period_r = 8'h00; // last full period in clocks
  initial count_pin_out = 1'b1; // pin idles high
  // sampled levels only, so process order never matters
  always @(posedge core_clk_in) begin
    prev_r <= clkout_in;
    run_r <= (clkout_in && !prev_r) ? 8'h01 : run_r + 8'h01;
    if (clkout_in && !prev_r) period_r <= run_r;
  end
  // three clocks per level so the synchroniser never misses an edge
  task pulse(input [7:0] n);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1) begin
        @(posedge core_clk_in);
        count_pin_out <= 1'b0;
        repeat (3) @(posedge core_clk_in);
        count_pin_out <= 1'b1;
        repeat (3) @(posedge core_clk_in);
      end
    end
  endtask
endmodule // tmr_pin_model

// ==== tmr_dual_top_tb.sv ====
// self-checking bench for the dual timer
`timescale 1ns/1ps
module tmr_dual_top_tb;
  reg clk = 1'b0; // 250 MHz core clock
  reg rst_n = 1'b0; // reset, active low
  reg [7:0] addr = 8'h00; // register address
  reg [7:0] wdata = 8'h00; // write data
  reg wr_s = 1'b0; // write strobe
  reg rd_s = 1'b0; // read strobe
  reg [2:0] src0 = 3'h0; // timer zero gates: pin, flag, keypad
  reg [2:0] src1 = 3'h0; // timer one gates: pin, flag, serial
  reg [2:0] tk = 3'h0; // free-running divider for the two external tick inputs
  wire [7:0] rdata;
  wire pin0, pin1, ck0, ck1, irq0, irq1, ovf;
  reg [7:0] got; // last value read
  integer err_total = 0;
  integer checked = 0;
  integer i, n;
  always #2 clk = ~clk;
  // slow tick every eight clocks, prescale tick every four, so the two differ
  always @(posedge clk) tk <= tk + 3'h1;
  tmr_dual_top tmr_dual_top_i (
    .core_clk_in(clk), .rstn_in(rst_n), .sfr_addr_in(addr), .sfr_wr_in(wr_s),
    .sfr_wdata_in(wdata), .sfr_rd_in(rd_s), .sfr_rdata_out(rdata),
    .timer_zero_count_pin_in(pin0), .timer_one_count_pin_in(pin1),
    .ext_int0_pin_in(src0[0]), .ext_int1_pin_in(src1[0]),
    .timer_two_flag_in(src0[1]), .timer_three_flag_in(src1[1]),
    .keypad_event_in(src0[2]), .serial_tx_flag_in(src1[2]),
    .slow_osc_tick_in(tk == 3'h0), .wdt_prescale_tick_in(tk[1:0] == 2'h0),
    .timer_zero_clkout_pin_out(ck0), .timer_one_clkout_pin_out(ck1),
    .timer_zero_irq_out(irq0), .timer_one_irq_out(irq1),
    .timer_one_overflow_pulse_out(ovf));
  tmr_pin_model tmr_pin_model_i0 (.core_clk_in(clk), .clkout_in(ck0), .count_pin_out(pin0));
  tmr_pin_model tmr_pin_model_i1 (.core_clk_in(clk), .clkout_in(ck1), .count_pin_out(pin1));
  // verdict and end of run
  task summarize;
    begin
      $display("checks %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [7:0] g, input [7:0] e);
    begin
      checked = checked + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("wrong value at %0t: got %h, expected %h", $time, g, e);
      end
    end
  endtask
  // one-cycle write strobe, then a gap before the next
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
    end
  endtask
  // read data lands one edge after the strobe and then holds
  task rdq(input [7:0] a);
    begin
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      @(posedge clk);
      got = rdata;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      rdq(a);
      chk(got, e);
    end
  endtask
  // clocks between two overflow pulses of timer one into n
  task span;
    integer k;
    begin
      for (k = 0; k < 3000 && ovf !== 1'b1; k = k + 1) @(posedge clk);
      @(posedge clk);
      for (n = 1; n < 3000 && ovf !== 1'b1; n = n + 1) @(posedge clk);
      if (k == 3000 || n == 3000) begin
        err_total = err_total + 1;
        $display("wrong value at %0t: no overflow pulse", $time);
        summarize;
      end
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    // reset values, last address unmapped
    for (i = 0; i < 10; i = i + 1)
      rd(i < 6 ? 8'h88 + i[7:0] : (i < 9 ? 8'h9D + i[7:0] : 8'h00), 8'h00);
    wr(8'hA3, 8'hFF);
    rd(8'hA3, 8'h0F);
    wr(8'h00, 8'h5A);
    rd(8'h00, 8'h00);
    wr(8'hA3, 8'h00);
    // timer one auto-reload, slow then fast
    wr(8'h89, 8'h20);
    wr(8'h8D, 8'hFC);
    wr(8'h8B, 8'hFC);
    wr(8'h88, 8'h40);
    span;
    span;
    chk(n[7:0], 8'h30);
    wr(8'hA3, 8'h08);
    span;
    span;
    chk(n[7:0], 8'h04);
    rd(8'h8D, 8'hFC);
    rd(8'h88, 8'hC0);
    wr(8'h89, 8'h30);
    rdq(8'h8B);
    i = got;
    repeat (100) @(posedge clk);
    rd(8'h8B, i[7:0]);
    // every gate source blocks, then passes
    for (i = 1; i < 4; i = i + 1) begin
      wr(8'h88, 8'h00);
      wr(8'h89, {i[0], 3'b001, i[0], 3'b001});
      wr(8'hA5, {6'h00, i[1], i[1]});
      wr(8'h8A, 8'h00);
      wr(8'h8B, 8'h00);
      wr(8'h88, 8'h50);
      repeat (40) @(posedge clk);
      rd(8'h8A, 8'h00);
      rd(8'h8B, 8'h00);
      src0 <= 3'h1 << (i - 1);
      src1 <= 3'h1 << (i - 1);
      repeat (40) @(posedge clk);
      rdq(8'h8A);
      chk({7'h00, |got}, 8'h01);
      rdq(8'h8B);
      chk({7'h00, |got}, 8'h01);
      src0 <= 3'h0;
      src1 <= 3'h0;
    end
    // pin counting, carry into the high byte
    wr(8'h88, 8'h00);
    wr(8'hA5, 8'h00);
    wr(8'hA3, 8'h00); // fast select would turn the timer one pin source into sysclk/48
    wr(8'h89, 8'h55);
    wr(8'h8A, 8'hFF);
    wr(8'h8C, 8'h00);
    wr(8'h8B, 8'h00);
    wr(8'h88, 8'h50);
    tmr_pin_model_i0.pulse(8'd2);
    tmr_pin_model_i1.pulse(8'd5);
    rd(8'h8A, 8'h01);
    rd(8'h8C, 8'h01);
    rd(8'h8B, 8'h05);
    // pwm: high while low count reaches the high byte
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h00);
    wr(8'hA3, 8'h04);
    wr(8'h8C, 8'h80);
    wr(8'h8A, 8'h00);
    wr(8'h88, 8'h10);
    repeat (8) @(posedge clk);
    n = 0;
    repeat (256) begin
      @(posedge clk);
      if (ck0 === 1'b1) n = n + 1;
    end
    chk(n[7:0], 8'h80);
    rd(8'h88, 8'h30);
    chk({7'h00, irq0}, 8'h01);
    // split: high byte runs on timer one's run bit and flag
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h03);
    wr(8'h8C, 8'hF0);
    wr(8'h8A, 8'h00);
    wr(8'h88, 8'h40);
    repeat (40) @(posedge clk);
    rd(8'h8A, 8'h00);
    rd(8'h88, 8'hC0);
    chk({7'h00, irq1}, 8'h01);
    // clock out on both timers, programmed in the required order
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h00);
    wr(8'hA3, 8'h08);
    wr(8'h8D, 8'hFE);
    wr(8'h8B, 8'hFE);
    wr(8'h8C, 8'hFD);
    wr(8'h8A, 8'hFD);
    wr(8'hA3, 8'h0B);
    wr(8'h88, 8'h50);
    repeat (400) @(posedge clk);
    chk(tmr_pin_model_i1.period_r, 8'h04);
    chk(tmr_pin_model_i0.period_r, 8'h48);
    rd(8'h88, 8'hF0);
    chk({6'h00, irq1, irq0}, 8'h00);
    span;
    span;
    chk(n[7:0], 8'h02);
    // timer zero prescaler sources 011..111 over an exact 960-clock run window
    wr(8'h88, 8'h00);
    wr(8'h8D, 8'hFC);
    wr(8'h8B, 8'hFC);
    for (i = 3; i < 8; i = i + 1) begin
      wr(8'h89, {4'h2, 1'b0, i[0], 2'b01});
      wr(8'hA3, {4'h0, 1'b1, i[1], 2'b00});
      wr(8'hA4, {7'h00, i[2]});
      wr(8'h8A, 8'h00);
      wr(8'h88, 8'h50);
      repeat (958) @(posedge clk);
      wr(8'h88, 8'h40);
      n = (i == 4) ? 8'h14 : (i == 6) ? 8'h05 : (i == 3) ? 8'h78 : 8'hF0;
      rd(8'h8A, n[7:0]);
    end
    summarize;
  end
endmodule // tmr_dual_top_tb
bind tmr_dual_top tmr_dual_props tmr_dual_props_i (
  .core_clk_in(core_clk_in), .rstn_in(rstn_in), .sfr_addr_in(sfr_addr_in),
  .sfr_wr_in(sfr_wr_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rd_in(sfr_rd_in),
  .sfr_rdata_out(sfr_rdata_out), .timer_zero_irq_out(timer_zero_irq_out),
  .timer_one_irq_out(timer_one_irq_out),
  .timer_one_overflow_pulse_out(timer_one_overflow_pulse_out));
